// >>> core/jpes_consts.vh
// Constants for the test-port enable and security gate.
`ifndef JPES_CONSTS_VH
`define JPES_CONSTS_VH
`define JPES_ADDR_W 8
`define JPES_OFS_ENABLE 8'hc7
`define JPES_OFS_CONFIG 8'hc8
`define JPES_OFS_STATUS 8'hc9
`define JPES_ENABLE_RST 1'b0
`define JPES_CONFIG_RST 8'h00
`define JPES_BIT_EN 0
`define JPES_CFG_DEDICATE 0
`define JPES_CFG_SECURE 1
`define JPES_NSECT 12
`define JPES_PROT_RST 12'h000
`define JPES_OP_W 2
`define JPES_OP_NONE 2'h0
`define JPES_OP_CHIP_ERASE 2'h1
`define JPES_OP_SECT_ERASE 2'h2
`define JPES_OP_PROG_READ 2'h3
`define JPES_BLANK_BYTE 8'hff
`endif

// >>> core/jpes_top.v
// Test-port pin gating, security lock and sector erase protection.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "jpes_consts.vh"
// Summary of operation
// - While secured, no memory data goes back to programmer or serial port.
// - While secured, only full chip erase passes; other program/erase/verify blocked.
// - Completed full chip erase clears security and blanks the device.
// - Each sector has a protect bit; erase to a protected sector is rejected.
// - Shipped state: memory and logic bits read as one.
// - Shipped state: configuration register bits are zero.
// - Enable register bit 0 one enables the port, zero disables it.
// - With pins dedicated by configuration, chip reset does not disturb sessions.
// - With pins enabled only by register, chip reset aborts and blocks sessions.
// - Pins go to test use on dedication bit, register bit or product term.
// - Chip reset clears the register enable bit; software may clear it too.
// - Data output stays input until the enable command arrives.
module jpes_top (
	input wire mclk_i,
	input wire rstn_i,
	input wire chip_reset_i,
	input wire [`JPES_ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire test_pins_product_term_i,
	input wire [6:0] portc_in_i,
	output wire [6:0] portc_out_o,
	output wire [6:0] portc_oe_o,
	input wire [6:0] gpio_out_i,
	input wire [6:0] gpio_oe_i,
	output wire [6:0] gpio_in_o,
	output wire test_tck_rise_o,
	output reg test_tms_o,
	output reg test_tdi_o,
	input wire test_tdo_i,
	input wire insystem_config_enable_cmd_i,
	input wire ext_enable_i,
	input wire program_busy_i,
	input wire program_error_i,
	input wire [`JPES_OP_W-1:0] op_i,
	input wire [3:0] op_sector_i,
	input wire op_valid_i,
	input wire op_done_i,
	input wire [7:0] mem_rdata_i,
	output wire session_active_o,
	output wire op_accept_o,
	output wire op_reject_o,
	output wire [7:0] mem_rdata_o
);
	reg rst_s1_q, rst_s2_q;
	wire rstn;
	reg enable_q;
	reg [7:0] config_q;
	reg [`JPES_NSECT-1:0] prot_q;
	reg [2:0] tck_q, tms_q, tdi_q, crst_q;
	reg cmd_q, ext_q;
	reg erase_pend_q;
	reg crst_lvl_q;
	wire chip_rst;
	wire port_on;
	wire session_ok;
	wire secured;
	wire sect_prot;
	wire allowed;

	// Reset release passes two flip-flops so the rest sees a clean edge.
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rstn = rst_s2_q;

	// Pin inputs pass three flops; a level counts once stages two and three agree.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			tck_q <= 3'h0;
			tms_q <= 3'h0;
			tdi_q <= 3'h0;
			crst_q <= 3'h0;
		end else begin
			tck_q <= {tck_q[1:0], portc_in_i[1]};
			tms_q <= {tms_q[1:0], portc_in_i[0]};
			tdi_q <= {tdi_q[1:0], portc_in_i[5]};
			crst_q <= {crst_q[1:0], chip_reset_i};
		end
	end

	// Chip reset level moves only when stages two and three agree.
	// A one-sample glitch on the pin therefore never aborts a register-enabled session.
	// The cost is one more cycle of latency, which a reset pulse easily covers.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			crst_lvl_q <= 1'b0;
		end else if (crst_q[1] == crst_q[2]) begin
			crst_lvl_q <= crst_q[2];
		end
	end
	assign chip_rst = crst_lvl_q;

	// Filtered mode and data levels move only when two stages agree.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			test_tms_o <= 1'b0;
			test_tdi_o <= 1'b0;
		end else begin
			if (tms_q[1] == tms_q[2]) begin
				test_tms_o <= tms_q[2];
			end
			if (tdi_q[1] == tdi_q[2]) begin
				test_tdi_o <= tdi_q[2];
			end
		end
	end
	// Rising clock edge seen when the agreed level goes from low to high.
	reg tck_lvl_q;
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			tck_lvl_q <= 1'b0;
		end else if (tck_q[1] == tck_q[2]) begin
			tck_lvl_q <= tck_q[2];
		end
	end
	assign test_tck_rise_o = port_on & session_ok & (tck_q[1] & tck_q[2]) & ~tck_lvl_q;

	// Register file; configuration starts all zero like a shipped part.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			enable_q <= `JPES_ENABLE_RST;
			config_q <= `JPES_CONFIG_RST;
			prot_q <= `JPES_PROT_RST;
		end else begin
			if (chip_rst) begin
				enable_q <= `JPES_ENABLE_RST;
			end else if (wr_i && addr_i == `JPES_OFS_ENABLE) begin
				// Upper bits are ignored; software is expected to write them zero.
				enable_q <= wdata_i[`JPES_BIT_EN];
			end
			if (erase_pend_q && op_done_i) begin
				config_q[`JPES_CFG_SECURE] <= 1'b0;
				prot_q <= `JPES_PROT_RST;
			end else if (wr_i && addr_i == `JPES_OFS_CONFIG) begin
				config_q <= wdata_i;
			end else if (wr_i && addr_i == `JPES_OFS_STATUS) begin
				prot_q <= {wdata_i[3:0], wdata_i};
			end
		end
	end

	// Read data one cycle after the strobe; unmapped addresses read zero.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`JPES_OFS_ENABLE: rdata_o <= {7'h00, enable_q};
				`JPES_OFS_CONFIG: rdata_o <= config_q;
				`JPES_OFS_STATUS: rdata_o <= {4'h0, cmd_q, erase_pend_q, port_on, session_ok};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Dedicated pins ignore chip reset; register-only enable is killed by it.
	assign port_on = config_q[`JPES_CFG_DEDICATE] | enable_q | test_pins_product_term_i;
	assign session_ok = config_q[`JPES_CFG_DEDICATE] | ~chip_rst;

	// Enable command arms data output and extension pins; losing the port drops it.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			cmd_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (!port_on || !session_ok) begin
			cmd_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (insystem_config_enable_cmd_i) begin
			cmd_q <= 1'b1;
			ext_q <= ext_enable_i;
		end
	end
	assign session_active_o = cmd_q;

	// Pin muxing: test functions take pins 0,1,5,6 and, when armed, 3 and 4.
	wire [6:0] test_mask = {port_on, port_on, ext_q, ext_q, 1'b0, port_on, port_on};
	wire [6:0] test_out = {test_tdo_i, 1'b0, ~program_error_i, ~program_busy_i, 3'h0};
	wire [6:0] test_oe = {cmd_q, 1'b0, ext_q, ext_q, 3'h0};
	assign portc_out_o = (test_mask & test_out) | (~test_mask & gpio_out_i);
	assign portc_oe_o = (test_mask & test_oe) | (~test_mask & gpio_oe_i);
	assign gpio_in_o = portc_in_i & ~test_mask;

	// Security and protection screening of instructions from the serial side.
	// Sector numbers beyond the last sector count as protected, so a stray erase is refused.
	// Screening is combinational so the verdict stands in the same cycle as the request.
	assign secured = config_q[`JPES_CFG_SECURE];
	assign sect_prot = (op_sector_i < `JPES_NSECT) ? prot_q[op_sector_i] : 1'b1;
	assign allowed = cmd_q & session_ok & (op_i != `JPES_OP_NONE)
		& (~secured | (op_i == `JPES_OP_CHIP_ERASE))
		& ~((op_i == `JPES_OP_SECT_ERASE) & sect_prot);
	assign op_accept_o = op_valid_i & allowed;
	assign op_reject_o = op_valid_i & ~allowed;
	// Secured parts hand back the blank pattern so nothing leaks.
	assign mem_rdata_o = secured ? `JPES_BLANK_BYTE : mem_rdata_i;

	// Track an accepted chip erase until its completion clears the lock.
	always @(posedge mclk_i or negedge rstn) begin
		if (!rstn) begin
			erase_pend_q <= 1'b0;
		end else if (op_done_i) begin
			erase_pend_q <= 1'b0;
		end else if (op_accept_o && op_i == `JPES_OP_CHIP_ERASE) begin
			erase_pend_q <= 1'b1;
		end
	end
endmodule // jpes_top

// >>> test/jpes_top_asserts.sv
// Checker for pin gating, data masking and operation gating.
`timescale 1ns/100ps
`include "jpes_consts.vh"
module jpes_top_asserts (
	input wire mclk_i, rstn_i, rd_i, op_valid_i, op_accept_o, op_reject_o,
	input wire session_active_o, test_pins_product_term_i, test_tck_rise_o,
	input wire [1:0] op_i,
	input wire [6:0] portc_in_i, portc_oe_o,
	input wire [7:0] rdata_o, mem_rdata_i, mem_rdata_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// Each output is tied to the input that causes it.
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data without read");
	chk_mask_ff: assert property (mem_rdata_o != mem_rdata_i |-> mem_rdata_o == 8'hff)
		else $error("memory data altered");
	chk_op_excl: assert property (op_accept_o |-> !op_reject_o && op_valid_i)
		else $error("bad accept");
	chk_accept_armed: assert property (op_accept_o |-> session_active_o)
		else $error("accept without session");
	chk_secure_erase: assert property (op_accept_o && mem_rdata_o != mem_rdata_i
		|-> op_i == `JPES_OP_CHIP_ERASE)
		else $error("secured op accepted");
	chk_pins_input: assert property (session_active_o |-> portc_oe_o[1:0] == 2'b00
		&& !portc_oe_o[5] && portc_oe_o[6])
		else $error("session pin direction");
	chk_pterm_pins: assert property (test_pins_product_term_i[*6] |-> !portc_oe_o[1])
		else $error("product term ignored");
	chk_tck_pulse: assert property (test_tck_rise_o |-> $past(portc_in_i[1]) ##1 !test_tck_rise_o)
		else $error("clock rise pulse");
	cov_accept: cover property (op_accept_o);
	cov_reject: cover property (op_reject_o);
	cov_session: cover property ($rose(session_active_o));
endmodule // jpes_top_asserts
bind jpes_top jpes_top_asserts u_chk (.*);

// >>> test/jpes_ctrl_model.sv
// Behavioural programming controller driving the serial link pins.
`timescale 1ns/100ps
module jpes_ctrl_model (
	input wire run_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	initial {tck_o, tms_o, tdi_o} = 3'b010;
	// The clock stands low between frames; data move on its falling edge.
	always begin
		wait (run_i);
		#80 tck_o = 1'b1;
		#80 tck_o = 1'b0;
		{tms_o, tdi_o} = ~{tms_o, tdi_o};
	end
endmodule // jpes_ctrl_model

// >>> test/jpes_top_test.sv
// Self-checking bench for the test-port gate.
`timescale 1ns/100ps
`include "jpes_consts.vh"
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module jpes_top_test;
	logic mclk_i = 0, rstn_i = 0, chip_reset_i = 0, wr_i = 0, rd_i = 0, pt = 0, cmd = 0;
	logic op_valid_i = 0, op_done_i = 0, run = 0, tck, tms, tdi, acc, rej, ses;
	logic busy = 0, rise, tms_lvl, tdi_lvl;
	logic [6:0] gpio_in;
	int tck_edges = 0, rises = 0, e0 = 0, r0 = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, mem_rdata_i = 8'h5a, rdata_o, mem_rdata_o;
	logic [1:0] op_i = 0;
	logic [3:0] sect = 0;
	logic [6:0] pin, pout, poe;
	int num_errors = 0, checks_done = 0, cyc = 0;
	always #2 mclk_i = ~mclk_i;
	// A released data-out pin is pulled high.
	assign pin = {poe[6] ? pout[6] : 1'b1, tdi, 3'b111, tck, tms};
	jpes_ctrl_model i_ctrl (.run_i(run), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
	jpes_top i_dut (.mclk_i, .rstn_i, .chip_reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .test_pins_product_term_i(pt), .portc_in_i(pin), .portc_out_o(pout),
		.portc_oe_o(poe), .gpio_out_i(7'h55), .gpio_oe_i(7'h7f), .gpio_in_o(gpio_in),
		.test_tck_rise_o(rise), .test_tms_o(tms_lvl), .test_tdi_o(tdi_lvl), .test_tdo_i(tdi),
		.insystem_config_enable_cmd_i(cmd), .ext_enable_i(1'b1), .program_busy_i(busy),
		.program_error_i(1'b0), .op_i, .op_sector_i(sect), .op_valid_i, .op_done_i,
		.mem_rdata_i, .session_active_o(ses), .op_accept_o(acc), .op_reject_o(rej),
		.mem_rdata_o);
	// Partner clock edges and the design's rise pulses are counted independently.
	always @(posedge tck) tck_edges++;
	always @(posedge mclk_i) if (rise) rises <= rises + 1;
	task automatic w(int n); repeat (n) @(posedge mclk_i); endtask
	task automatic wr(logic [7:0] a, d);
		@(posedge mclk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
		@(posedge mclk_i); wr_i <= 0;
	endtask
	task automatic rd(logic [7:0] a, e);
		@(posedge mclk_i); addr_i <= a; rd_i <= 1;
		@(posedge mclk_i); rd_i <= 0;
		@(negedge mclk_i); `CK("rdata", e, rdata_o)
	endtask
	// Accept and reject are combinational, so they are looked at mid-cycle.
	task automatic op(logic [1:0] c, logic [3:0] s, logic a);
		@(posedge mclk_i); op_i <= c; sect <= s; op_valid_i <= 1;
		@(negedge mclk_i); `CK("accept", a, acc) `CK("reject", !a, rej)
		@(posedge mclk_i); op_valid_i <= 0; op_done_i <= a;
		@(posedge mclk_i); op_done_i <= 0;
	endtask
	task automatic arm;
		cmd <= 1; w(1); cmd <= 0; w(4); @(negedge mclk_i);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Cycle ceiling well above the six hundred or so cycles the tests need.
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin num_errors++; test_done; end
	end
	initial begin
		w(3); rstn_i <= 1; w(3);
		rd(`JPES_OFS_ENABLE, 8'h00);
		rd(`JPES_OFS_CONFIG, 8'h00);
		`CK("gpio oe", 7'h7f, poe)
		`CK("gpio in", 7'h5d, gpio_in)
		`CK("gpio out", 7'h55, pout)
		@(posedge mclk_i); pt <= 1; w(8); @(negedge mclk_i); `CK("pt oe", 1'b0, poe[1])
		`CK("pt gpio in", 7'h1c, gpio_in)
		@(posedge mclk_i); pt <= 0; wr(`JPES_OFS_ENABLE, 8'h01);
		rd(`JPES_OFS_ENABLE, 8'h01);
		`CK("tdo oe", 1'b0, poe[6])
		run <= 1; op(`JPES_OP_CHIP_ERASE, 0, 0); arm;
		`CK("session", 1'b1, ses)
		`CK("tdo oe on", 1'b1, poe[6])
		`CK("ext pins", 4'hf, {poe[4:3], pout[4:3]})
		`CK("armed gpio in", 7'h04, gpio_in)
		w(1); busy <= 1; w(1); @(negedge mclk_i); `CK("busy pin", 1'b0, pout[3])
		w(1); busy <= 0;
		$display("test enable done");
		wr(`JPES_OFS_CONFIG, 8'h02); @(negedge mclk_i); `CK("mask", 8'hff, mem_rdata_o)
		op(`JPES_OP_PROG_READ, 0, 0);
		op(`JPES_OP_SECT_ERASE, 1, 0);
		op(`JPES_OP_CHIP_ERASE, 0, 1);
		rd(`JPES_OFS_CONFIG, 8'h00);
		`CK("open", 8'h5a, mem_rdata_o)
		$display("test security done");
		wr(`JPES_OFS_STATUS, 8'h01);
		op(`JPES_OP_SECT_ERASE, 0, 0);
		op(`JPES_OP_SECT_ERASE, 11, 1);
		$display("test protect done");
		chip_reset_i <= 1; w(4); chip_reset_i <= 0; w(4); @(negedge mclk_i);
		`CK("session", 1'b0, ses)
		rd(`JPES_OFS_ENABLE, 8'h00);
		op(`JPES_OP_PROG_READ, 0, 0);
		wr(`JPES_OFS_CONFIG, 8'h01); arm;
		@(posedge mclk_i); chip_reset_i <= 1; w(6); @(negedge mclk_i);
		`CK("session", 1'b1, ses)
		op(`JPES_OP_PROG_READ, 0, 1);
		$display("test chip reset done");
		// Stop the controller, let the pins settle, then count one burst of clocks.
		@(negedge mclk_i); run <= 0; w(60); e0 = tck_edges; r0 = rises;
		@(negedge mclk_i); run <= 1; w(400);
		@(negedge mclk_i); run <= 0; w(60); @(negedge mclk_i);
		`CK("tck edges", 1'b1, tck_edges - e0 >= 10)
		`CK("tck rises", tck_edges - e0, rises - r0)
		`CK("tms level", tms, tms_lvl)
		`CK("tdi level", tdi, tdi_lvl)
		$display("test link done");
		test_done;
	end
endmodule // jpes_top_test
